// ==== rps_device.sv ====
// Device end: power-up, resets, reset-complete flag and port choice
`timescale 1ns/1ps
module rps_device
  import rps_pkg::*;
#(
  parameter int unsigned HOLDOFF  = HOLDOFF_CYC,
  parameter int unsigned POWERUP  = POWERUP_CYC,
  parameter int unsigned RST_MIN  = RESET_MIN_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Supply monitor
  input  wire logic        supply_good,
  // Link
  rps_link_if.device       link,
  // Status
  output logic             device_active,
  output logic             spi_active,
  output logic             port_locked,
  output logic             dsp_running,
  output logic             full_power
);
  rps_state_e  state;
  logic [31:0] cnt;
  logic [2:0]  rst_sync;
  logic [2:0]  ss_sync;
  logic [2:0]  sg_sync;
  logic        rst_clean;
  logic        ss_clean;
  logic        sg_clean;
  logic [1:0]  strobe_cnt;
  logic [15:0] main_reg;
  logic [15:0] aux_reg;
  logic [15:0] thresh_reg;
  logic [15:0] run_reg;
  logic [15:0] event_a;
  logic        in_full;
  logic        pulse_ok;
  logic        sw_req;
  logic        hw_done;
  logic        sw_done;
  logic        boot_done;
  logic        wr_aux;
  logic        wr_ev_b;

  // Three-stage sync; change accepted when stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rst_sync <= 3'h7;
      ss_sync  <= 3'h7;
      sg_sync  <= 3'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[1:0], link.reset_pin_n};
      ss_sync  <= {ss_sync[1:0], link.port_select_strobe};
      sg_sync  <= {sg_sync[1:0], supply_good};
    end
  end

  // Filtered levels
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rst_clean <= 1'b1;
      ss_clean  <= 1'b1;
      sg_clean  <= 1'b0;
    end
    else
    begin
      if (rst_sync[2] == rst_sync[1])
        rst_clean <= rst_sync[1];
      if (ss_sync[2] == ss_sync[1])
        ss_clean <= ss_sync[1];
      if (sg_sync[2] == sg_sync[1])
        sg_clean <= sg_sync[1];
    end
  end

  // Pins sampled directly; host holds them steady around power states
  assign in_full   = ({link.power_state_pin_b, link.power_state_pin_a}
                      == PM_FULL);
  assign wr_aux    = link.reg_wr && (link.reg_sel == REG_AUX_SETTINGS);
  assign wr_ev_b   = link.reg_wr && (link.reg_sel == REG_EVENT_B);
  assign sw_req    = (state == RPS_READY) && in_full && link.reg_wr
                     && (link.reg_sel == REG_MAIN_SETTINGS)
                     && link.reg_wdata[SOFT_RESET_BIT];
  assign pulse_ok  = (cnt >= RST_MIN);
  assign boot_done = (state == RPS_BOOT) && (cnt >= POWERUP - 1);
  assign hw_done   = (state == RPS_HWRST) && rst_clean && pulse_ok;
  assign sw_done   = (state == RPS_SOFT_RESET_BIT) && (cnt >= SOFT_RESET_CYC - 1);

  // Sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= RPS_OFF;
      cnt   <= 32'h0;
    end
    else if (!sg_clean)
    begin
      state <= RPS_OFF;
      cnt   <= 32'h0;
    end
    else
    begin
      cnt <= cnt + 32'h1;
      unique case (state)
        RPS_OFF:
        begin
          state <= RPS_HOLDOFF;
          cnt   <= 32'h0;
        end
        RPS_HOLDOFF:
          if (cnt >= HOLDOFF - 1)
          begin
            state <= RPS_BOOT;
            cnt   <= 32'h0;
          end
        RPS_BOOT:
          if (boot_done)
            state <= RPS_READY;
        RPS_READY:
          if (in_full && !rst_clean)
          begin
            state <= RPS_HWRST;
            cnt   <= 32'h0;
          end
          else if (sw_req)
          begin
            state <= RPS_SOFT_RESET_BIT;
            cnt   <= 32'h0;
          end
        RPS_HWRST:
          if (rst_clean)
            state <= RPS_READY;
        RPS_SOFT_RESET_BIT:
          if (sw_done)
            state <= RPS_READY;
      endcase
    end
  end

  // Aux and threshold: defaulted only by power-up or long reset pulse
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state == RPS_OFF || state == RPS_BOOT || hw_done)
    begin
      aux_reg    <= AUX_DEFAULT;
      thresh_reg <= THRESH_DEFAULT;
    end
    else if (state == RPS_READY && in_full && link.reg_wr)
    begin
      if (link.reg_sel == REG_AUX_SETTINGS)
        aux_reg <= link.reg_wdata;
      if (link.reg_sel == REG_THRESHOLD)
        thresh_reg <= link.reg_wdata;
    end
  end

  // Other registers; soft reset also defaults them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state != RPS_READY)
    begin
      main_reg <= MAIN_DEFAULT;
      run_reg  <= RUN_STOP;
      event_a  <= 16'h0000;
    end
    else if (link.reg_wr && in_full)
    begin
      if (link.reg_sel == REG_MAIN_SETTINGS)
        main_reg <= link.reg_wdata & ~(16'h1 << SOFT_RESET_BIT);
      if (link.reg_sel == REG_RUN)
        run_reg <= link.reg_wdata;
      if (link.reg_sel == REG_EVENT_A)
        event_a <= event_a & ~link.reg_wdata;
    end
  end

  // Reset-complete flag, unmaskable; set wins over a write-one clear
  logic done_set;
  assign done_set = boot_done || hw_done || sw_done;
  logic flag_q;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || (state != RPS_READY && !done_set))
      flag_q <= 1'b0;
    else if (done_set)
      flag_q <= 1'b1;
    else if (wr_ev_b && link.reg_wdata[RESET_DONE_BIT])
      flag_q <= 1'b0;
  end

  // Port selection: two-wire by default, three falling strobes for SPI
  logic ss_prev;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || state == RPS_OFF || state == RPS_BOOT
        || state == RPS_HWRST)
    begin
      spi_active  <= 1'b0;
      port_locked <= 1'b0;
      strobe_cnt  <= 2'h0;
      ss_prev     <= 1'b1;
    end
    else
    begin
      ss_prev <= ss_clean;
      if (state == RPS_SOFT_RESET_BIT && !port_locked)
      begin
        spi_active <= 1'b0;
        strobe_cnt <= 2'h0;
      end
      else if (!port_locked && ss_prev && !ss_clean && !spi_active)
      begin
        if (strobe_cnt == 2'(SPI_STROBES - 1))
          spi_active <= 1'b1;
        strobe_cnt <= strobe_cnt + 2'h1;
      end
      if (state == RPS_READY && in_full && wr_aux && !port_locked)
      begin
        if (spi_active)
          port_locked <= 1'b1;
        else if (link.reg_wdata[TWO_WIRE_LOCK_BIT])
          port_locked <= 1'b1;
      end
    end
  end

  // Read data one cycle after the read strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      link.reg_rdata <= 16'h0000;
    else if (link.reg_rd)
      unique case (link.reg_sel)
        REG_MAIN_SETTINGS: link.reg_rdata <= main_reg;
        REG_AUX_SETTINGS:  link.reg_rdata <= aux_reg;
        REG_THRESHOLD:     link.reg_rdata <= thresh_reg;
        REG_EVENT_A:       link.reg_rdata <= event_a;
        REG_EVENT_B:       link.reg_rdata <= 16'(flag_q) << RESET_DONE_BIT;
        REG_RUN:           link.reg_rdata <= run_reg;
        default:           link.reg_rdata <= 16'h0000;
      endcase
    else
      link.reg_rdata <= 16'h0000;
  end

  // Status outputs registered
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      link.alert_line_b_n <= 1'b1;
      device_active       <= 1'b0;
      dsp_running         <= 1'b0;
      full_power          <= 1'b0;
    end
    else
    begin
      link.alert_line_b_n <= !flag_q;
      device_active       <= (state != RPS_OFF) && (state != RPS_HOLDOFF);
      dsp_running         <= (state == RPS_READY) && (run_reg == RUN_START);
      full_power          <= in_full;
    end
  end
endmodule

// ==== rps_pkg.sv ====
// Shared constants for the reset and port select sequencer
// Notes on behaviour
// - Stay inactive 26 ms after supply good
// - Host holds pin b low, a high
// - Full power-up takes about 40 ms
// - Host keeps reset pin high during power-up
// - Two-wire port first; three strobes select SPI
// - Aux bit 1 locks two-wire, ignores strobes
// - Aux write while SPI locks SPI
// - Lock released only by power or reset pin
// - Lock kept across power state changes
// - Full-power entry defaults every register; here registers keep their values across power state changes
// - Flag low during transition, set at end
// - Unmaskable flag; write one clears, alert high
// - Host waits alert low, then clears flags
// - Signal processor idle until host starts it
// - Supply loss makes device inactive
// - Reset pin acts only in full power
// - Reset low 10 us restores all defaults
// - Two-wire after reset; host repeats strobes
// - Host initialises, protects, writes run 0x0001
// - Soft reset bit 7 spares aux and threshold
// - Soft reset end clears bit, flags, alerts
// - Soft reset ignored in reduced states
package rps_pkg;
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned HOLDOFF_MS        = 26;
  localparam int unsigned POWERUP_MS        = 40;
  localparam int unsigned RESET_MIN_US      = 10;
  localparam int unsigned HOLDOFF_CYC       = HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned POWERUP_CYC       = POWERUP_MS * (CLK_HZ / 1000);
  localparam int unsigned RESET_MIN_CYC     = RESET_MIN_US * (CLK_HZ / 1000000);
  localparam int unsigned SOFT_RESET_CYC    = 64;
  localparam int unsigned SPI_STROBES       = 3;
  // Register selects on the device interface
  localparam logic [3:0]  REG_MAIN_SETTINGS = 4'h0;
  localparam logic [3:0]  REG_AUX_SETTINGS  = 4'h1;
  localparam logic [3:0]  REG_THRESHOLD     = 4'h2;
  localparam logic [3:0]  REG_EVENT_A       = 4'h3;
  localparam logic [3:0]  REG_EVENT_B       = 4'h4;
  localparam logic [3:0]  REG_RUN           = 4'h5;
  localparam int unsigned SOFT_RESET_BIT    = 7;
  localparam int unsigned TWO_WIRE_LOCK_BIT = 1;
  localparam int unsigned RESET_DONE_BIT    = 15;
  localparam logic [15:0] MAIN_DEFAULT      = 16'h0000;
  localparam logic [15:0] AUX_DEFAULT       = 16'h0000;
  localparam logic [15:0] THRESH_DEFAULT    = 16'h0000;
  localparam logic [15:0] RUN_START         = 16'h0001;
  localparam logic [15:0] RUN_STOP          = 16'h0000;
  // Power state pin codes {pin_b, pin_a}
  localparam logic [1:0]  PM_FULL           = 2'h1;
  localparam logic [1:0]  PM_ONE            = 2'h0;
  localparam logic [1:0]  PM_TWO            = 2'h2;
  localparam logic [1:0]  PM_SLEEP          = 2'h3;
  // Host controller register offsets
  localparam logic [3:0]  HOST_CTRL         = 4'h0;
  localparam logic [3:0]  HOST_STATUS       = 4'h1;
  localparam logic [3:0]  HOST_WDATA        = 4'h2;
  localparam logic [3:0]  HOST_RDATA        = 4'h3;
  localparam int unsigned HC_GO             = 0;
  localparam int unsigned HC_WRITE          = 1;
  localparam int unsigned HC_HWRESET        = 2;
  localparam int unsigned HC_SPI_SEL        = 3;
  localparam int unsigned HC_INIT           = 4;
  localparam int unsigned HC_SEL_LSB        = 8;
  localparam int unsigned HC_PM_LSB         = 12;
  localparam int unsigned STROBE_HALF_CYC   = 4;

  typedef enum logic [5:0]
  {
    RPS_OFF     = 6'h01,
    RPS_HOLDOFF = 6'h02,
    RPS_BOOT    = 6'h04,
    RPS_READY   = 6'h08,
    RPS_HWRST   = 6'h10,
    RPS_SOFT_RESET_BIT   = 6'h20
  } rps_state_e;
endpackage

// ==== rps_link_if.sv ====
// Pins between the metering device and its host controller
`timescale 1ns/1ps
interface rps_link_if;
  logic        reset_pin_n;
  logic        power_state_pin_a;
  logic        power_state_pin_b;
  logic        port_select_strobe;
  logic        alert_line_b_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_sel;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;

  modport device
  (
    input  reset_pin_n, power_state_pin_a, power_state_pin_b,
    input  port_select_strobe, reg_wr, reg_rd, reg_sel, reg_wdata,
    output alert_line_b_n, reg_rdata
  );
  modport host
  (
    output reset_pin_n, power_state_pin_a, power_state_pin_b,
    output port_select_strobe, reg_wr, reg_rd, reg_sel, reg_wdata,
    input  alert_line_b_n, reg_rdata
  );
endinterface

// ==== rps_host.sv ====
// Host end: drives mode pins, reset pin, strobes and register access
`timescale 1ns/1ps
module rps_host
  import rps_pkg::*;
#(
  parameter int unsigned RST_MIN = RESET_MIN_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Link
  rps_link_if.host         link
);
  logic [15:0] ctrl;
  logic [15:0] wreg;
  logic [15:0] rreg;
  logic        busy;
  logic        got_rd;
  logic [31:0] cnt;
  logic [2:0]  strobes;
  logic [2:0]  al_sync;
  logic        alert_low;
  logic        rd_pend;

  // Alert line sync, accepted when stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      al_sync   <= 3'h7;
      alert_low <= 1'b0;
    end
    else
    begin
      al_sync <= {al_sync[1:0], link.alert_line_b_n};
      if (al_sync[2] == al_sync[1])
        alert_low <= !al_sync[1];
    end
  end

  // Command engine: register access, reset pulse, SPI strobes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl                   <= 16'h0000;
      wreg                   <= 16'h0000;
      rreg                   <= 16'h0000;
      busy                   <= 1'b0;
      cnt                    <= 32'h0;
      strobes                <= 3'h0;
      rd_pend                <= 1'b0;
      link.reset_pin_n       <= 1'b1;
      link.power_state_pin_a <= 1'b1;
      link.power_state_pin_b <= 1'b0;
      link.port_select_strobe <= 1'b1;
      link.reg_wr            <= 1'b0;
      link.reg_rd            <= 1'b0;
      link.reg_sel           <= 4'h0;
      link.reg_wdata         <= 16'h0000;
    end
    else
    begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      rd_pend     <= link.reg_rd;
      if (rd_pend)
        rreg <= link.reg_rdata;
      if (wr && addr == HOST_WDATA)
        wreg <= wdata;
      if (wr && addr == HOST_CTRL && !busy)
      begin
        ctrl <= wdata;
        {link.power_state_pin_b, link.power_state_pin_a}
          <= wdata[HC_PM_LSB +: 2];
        if (wdata[HC_GO])
        begin
          link.reg_sel   <= wdata[HC_SEL_LSB +: 4];
          link.reg_wdata <= wreg;
          link.reg_wr    <= wdata[HC_WRITE];
          link.reg_rd    <= !wdata[HC_WRITE];
        end
        else if (wdata[HC_HWRESET])
        begin
          busy             <= 1'b1;
          cnt              <= 32'h0;
          link.reset_pin_n <= 1'b0;
        end
        else if (wdata[HC_SPI_SEL])
        begin
          busy    <= 1'b1;
          cnt     <= 32'h0;
          strobes <= 3'h0;
        end
      end
      else if (busy)
      begin
        cnt <= cnt + 32'h1;
        if (!link.reset_pin_n)
        begin
          if (cnt >= RST_MIN + 3)
          begin
            link.reset_pin_n <= 1'b1;
            if (ctrl[HC_SPI_SEL])
              cnt <= 32'h0;
            else
              busy <= 1'b0;
          end
        end
        else if (cnt == 32'(STROBE_HALF_CYC))
        begin
          cnt <= 32'h0;
          link.port_select_strobe <= !link.port_select_strobe;
          if (!link.port_select_strobe)
          begin
            strobes <= strobes + 3'h1;
            if (strobes == 3'(SPI_STROBES - 1))
              busy <= 1'b0;
          end
        end
      end
    end
  end

  // Software read port, data one cycle after strobe
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata <= 16'h0000;
    else if (rd)
      unique case (addr)
        HOST_CTRL:   rdata <= ctrl;
        HOST_STATUS: rdata <= {14'h0, alert_low, busy};
        HOST_WDATA:  rdata <= wreg;
        HOST_RDATA:  rdata <= rreg;
        default:     rdata <= 16'h0000;
      endcase
    else
      rdata <= 16'h0000;
  end
endmodule

// ==== rps_link_props.sv ====
// Checker on the pins between host controller and metering device
`timescale 1ns/1ps
module rps_link_props
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Link pins
  input  wire logic        reset_pin_n,
  input  wire logic        power_state_pin_a,
  input  wire logic        power_state_pin_b,
  input  wire logic        alert_line_b_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [3:0]  reg_sel,
  input  wire logic [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  logic full;
  logic flag_wr;
  logic soft_wr;

  // Decoded pins and writes; resets only count in full power
  assign full    = ({power_state_pin_b, power_state_pin_a} == PM_FULL);
  assign flag_wr = reg_wr && (reg_sel == REG_EVENT_B);
  assign soft_wr = reg_wr && (reg_sel == REG_MAIN_SETTINGS)
                   && reg_wdata[SOFT_RESET_BIT];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_clear;
    flag_wr && reg_wdata[RESET_DONE_BIT] && !alert_line_b_n
      |-> ##[1:3] alert_line_b_n;
  endproperty
  a_clear: assert property (p_clear)
    else $error("alert not released by flag clear");

  property p_keep;
    flag_wr && !reg_wdata[RESET_DONE_BIT] && !alert_line_b_n
      |=> !alert_line_b_n [*3];
  endproperty
  a_keep: assert property (p_keep)
    else $error("zero write disturbed the alert");

  property p_flag;
    reg_rd && (reg_sel == REG_EVENT_B) && !alert_line_b_n
      |=> reg_rdata[RESET_DONE_BIT];
  endproperty
  a_flag: assert property (p_flag)
    else $error("alert low but flag reads zero");

  property p_hwrst;
    (!reset_pin_n && full) [*8] |-> ##[0:6] alert_line_b_n;
  endproperty
  a_hwrst: assert property (p_hwrst)
    else $error("alert low through a full reset pulse");

  property p_reduced;
    !reset_pin_n && !full && !alert_line_b_n |=> !alert_line_b_n;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("reset pin acted in a reduced state");

  property p_soft_reset_bit;
    soft_wr && full
      |-> ##[1:4] alert_line_b_n ##[1:100] !alert_line_b_n;
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit)
    else $error("soft reset did not complete in time");

  property p_swign;
    soft_wr && !full && alert_line_b_n |=> alert_line_b_n [*8];
  endproperty
  a_swign: assert property (p_swign)
    else $error("soft reset taken in a reduced state");

  property p_swbit;
    reg_rd && (reg_sel == REG_MAIN_SETTINGS)
      |=> !reg_rdata[SOFT_RESET_BIT];
  endproperty
  a_swbit: assert property (p_swbit)
    else $error("soft reset bit reads back set");
endmodule

// ==== reset_and_port_select_seq_tb_top.sv ====
// Testbench joining device and host ends over the link interface
`timescale 1ns/1ps
module reset_and_port_select_seq_tb_top
  import rps_pkg::*;
;
  typedef struct
  {
    logic        wr_en;
    logic [3:0]  sel;
    logic [15:0] data;
    logic [15:0] mask;
    logic [15:0] exp;
  } rps_row_s;

  logic        core_clk;
  logic        rst_n;
  logic        supply_good;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        device_active;
  logic        spi_active;
  logic        port_locked;
  logic        dsp_running;
  logic        full_power;
  logic        alert;
  logic [1:0]  pm;
  logic [15:0] rv;
  int          fails;
  int          tests_run;
  rps_row_s    rows [5];

  localparam int GO_WR = (1 << HC_GO) | (1 << HC_WRITE);
  // Go bit would win over these in the host, so they stand alone
  localparam int GO_HW = (1 << HC_HWRESET);
  localparam int GO_SP = (1 << HC_SPI_SEL);

  // Free-running core clock, 25 ns period
  always #12.5 core_clk = ~core_clk;

  rps_link_if rps_link_if_inst ();
  assign alert = rps_link_if_inst.alert_line_b_n;

  // Short counts keep the power-up walk to under two hundred cycles
  rps_device #(.HOLDOFF(50), .POWERUP(100), .RST_MIN(8)) rps_device_inst
  (
    .core_clk(core_clk), .rst_n(rst_n), .supply_good(supply_good),
    .link(rps_link_if_inst.device), .device_active(device_active),
    .spi_active(spi_active), .port_locked(port_locked),
    .dsp_running(dsp_running), .full_power(full_power)
  );
  rps_host #(.RST_MIN(8)) rps_host_inst
  (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link(rps_link_if_inst.host)
  );
  rps_link_props rps_link_props_inst
  (
    .core_clk(core_clk), .rst_n(rst_n),
    .reset_pin_n(rps_link_if_inst.reset_pin_n),
    .power_state_pin_a(rps_link_if_inst.power_state_pin_a),
    .power_state_pin_b(rps_link_if_inst.power_state_pin_b),
    .alert_line_b_n(alert), .reg_wr(rps_link_if_inst.reg_wr),
    .reg_rd(rps_link_if_inst.reg_rd), .reg_sel(rps_link_if_inst.reg_sel),
    .reg_wdata(rps_link_if_inst.reg_wdata),
    .reg_rdata(rps_link_if_inst.reg_rdata)
  );

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_bit(input string name, input logic seen,
                           input logic exp);
    check(name, {15'h0, seen}, {15'h0, exp});
  endtask

  // Software port cycles; strobes last one cycle
  task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Host command, then poll busy; bounded so a stuck host cannot hang
  task automatic cmd(input logic [3:0] sel, input int bits);
    int          n;
    logic [15:0] st;
    n = 0;
    st = 16'h0001;
    sw_wr(HOST_CTRL, {2'h0, pm, sel, 8'(bits)});
    repeat (2) @(posedge core_clk);
    while (st[0] !== 1'b0 && n < 400)
    begin
      sw_rd(HOST_STATUS, st);
      n++;
    end
    if (n >= 400)
      check("host busy", st, 16'h0000);
  endtask

  task automatic dev_wr(input logic [3:0] sel, input logic [15:0] d);
    sw_wr(HOST_WDATA, d);
    cmd(sel, GO_WR);
  endtask

  task automatic dev_rd(input logic [3:0] sel, output logic [15:0] d);
    cmd(sel, 1 << HC_GO);
    sw_rd(HOST_RDATA, d);
  endtask

  task automatic wait_alert(input logic lvl, input int lim);
    int n;
    n = 0;
    while (alert !== lvl && n < lim)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check_bit("alert line", alert, lvl);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the thousand or so cycles the run needs
  initial
  begin
    #(60000 * 25);
    fails++;
    end_of_test();
  end

  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    supply_good = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    pm = PM_FULL;
    fails = 0;
    tests_run = 0;
    rows[0] = '{1'b0, REG_MAIN_SETTINGS, 16'h0, 16'hffff, MAIN_DEFAULT};
    rows[1] = '{1'b0, REG_AUX_SETTINGS, 16'h0, 16'hffff, AUX_DEFAULT};
    rows[2] = '{1'b0, REG_THRESHOLD, 16'h0, 16'hffff, THRESH_DEFAULT};
    rows[3] = '{1'b0, REG_EVENT_B, 16'h0, 16'h8000, 16'h8000};
    rows[4] = '{1'b1, REG_THRESHOLD, 16'h1234, 16'hffff, 16'h1234};
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    supply_good <= 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    check_bit("active early", device_active, 1'b0);
    check_bit("alert early", alert, 1'b1);
    check_bit("reset pin", rps_link_if_inst.reset_pin_n, 1'b1);
    wait_alert(1'b0, 300);
    check_bit("full power", full_power, 1'b1);
    check_bit("spi at start", spi_active, 1'b0);
    check_bit("dsp idle", dsp_running, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      if (rows[i].wr_en)
        dev_wr(rows[i].sel, rows[i].data);
      dev_rd(rows[i].sel, rv);
      check("row read", rv & rows[i].mask, rows[i].exp);
    end
    // Host has long since synchronised the low alert line
    sw_rd(HOST_STATUS, rv);
    check("alert seen", rv & 16'h0002, 16'h0002);
    // Flag clears on a one only
    dev_wr(REG_EVENT_B, 16'h0000);
    check_bit("zero write", alert, 1'b0);
    dev_wr(REG_EVENT_B, 16'h8000);
    check_bit("flag clear", alert, 1'b1);
    dev_rd(REG_EVENT_B, rv);
    check("flag read", rv & 16'h8000, 16'h0000);
    dev_wr(REG_RUN, RUN_START);
    check_bit("dsp started", dsp_running, 1'b1);
    // Soft reset spares the threshold
    dev_wr(REG_MAIN_SETTINGS, 16'h0080);
    wait_alert(1'b0, 300);
    dev_rd(REG_MAIN_SETTINGS, rv);
    check("soft bit", rv & 16'h0080, 16'h0000);
    dev_rd(REG_THRESHOLD, rv);
    check("threshold kept", rv, 16'h1234);
    check_bit("dsp idle again", dsp_running, 1'b0);
    dev_wr(REG_EVENT_B, 16'h8000);
    // SPI chosen, then locked by an aux write
    cmd(4'h0, GO_SP);
    check_bit("spi chosen", spi_active, 1'b1);
    check_bit("not locked", port_locked, 1'b0);
    dev_wr(REG_AUX_SETTINGS, 16'h0000);
    check_bit("spi locked", port_locked, 1'b1);
    dev_wr(REG_MAIN_SETTINGS, 16'h0080);
    wait_alert(1'b0, 300);
    check_bit("spi kept", spi_active, 1'b1);
    // Flag left set so the reduced-state pulse is watched on alert
    pm = PM_SLEEP;
    cmd(4'h0, GO_HW);
    check_bit("reduced lock", port_locked, 1'b1);
    check_bit("reduced state", full_power, 1'b0);
    // Pin must read high again before full power, else a short reset
    repeat (8) @(posedge core_clk);
    pm = PM_FULL;
    sw_wr(HOST_CTRL, {2'h0, pm, 12'h000});
    repeat (300) @(posedge core_clk);
    check_bit("lock kept", port_locked, 1'b1);
    check_bit("spi after mode", spi_active, 1'b1);
    dev_wr(REG_EVENT_B, 16'h8000);
    cmd(4'h0, GO_HW);
    wait_alert(1'b0, 400);
    check_bit("lock released", port_locked, 1'b0);
    check_bit("two-wire back", spi_active, 1'b0);
    dev_rd(REG_THRESHOLD, rv);
    check("threshold reset", rv, THRESH_DEFAULT);
    dev_wr(REG_EVENT_B, 16'h8000);
    // Two-wire lock refuses strobes
    dev_wr(REG_AUX_SETTINGS, 16'h0002);
    check_bit("two-wire lock", port_locked, 1'b1);
    cmd(4'h0, GO_SP);
    check_bit("strobes ignored", spi_active, 1'b0);
    pm = PM_SLEEP;
    dev_wr(REG_MAIN_SETTINGS, 16'h0080);
    repeat (100) @(posedge core_clk);
    check_bit("soft ignored", alert, 1'b1);
    supply_good <= 1'b0;
    repeat (10) @(posedge core_clk);
    check_bit("supply lost", device_active, 1'b0);
    end_of_test();
  end
endmodule
